/* design/crwl_pkg.sv */
// shared constants for the control region write lock
package crwl_pkg;
  localparam int          CRWL_NUM_REGIONS = 5;
  localparam int          CRWL_ADDR_W      = 12;
  localparam int          CRWL_DATA_W      = 32;
  localparam int          CRWL_REGION_W    = 3;
  // region of the control space decoded from address bits [11:9]
  localparam int          CRWL_REGION_LSB  = 9;
  // lock words sit at the top of region 0, one word apart
  localparam logic [11:0] CRWL_LOCK_BASE   = 12'h1E0;
  localparam logic [11:0] CRWL_LOCK_STRIDE = 12'h004;
  localparam logic [2:0]  CRWL_FIFTH_IDX   = 3'h4;
  localparam logic [31:0] CRWL_LOCK_KEY5   = 32'h143F832C;
  localparam logic [31:0] CRWL_UNLOCK_KEY5 = 32'h6F361E05;
  // keys of the other regions; values arbitrary
  localparam logic [31:0] CRWL_LOCK_KEY0   = 32'h1A1A0001;
  localparam logic [31:0] CRWL_UNLOCK_KEY0 = 32'h2B2B0001;
  localparam logic [31:0] CRWL_LOCK_KEY1   = 32'h1A1A0002;
  localparam logic [31:0] CRWL_UNLOCK_KEY1 = 32'h2B2B0002;
  localparam logic [31:0] CRWL_LOCK_KEY2   = 32'h1A1A0003;
  localparam logic [31:0] CRWL_UNLOCK_KEY2 = 32'h2B2B0003;
  localparam logic [31:0] CRWL_LOCK_KEY3   = 32'h1A1A0004;
  localparam logic [31:0] CRWL_UNLOCK_KEY3 = 32'h2B2B0004;
  localparam logic [31:0] CRWL_UNLOCKED_RD = 32'h00000000;
  localparam logic [4:0]  CRWL_LOCK_RESET  = 5'h00;
  localparam logic [31:0] CRWL_ZERO32      = 32'h00000000;
  localparam logic [3:0]  CRWL_PAD_SETTLE  = 4'h2;

  typedef enum logic [2:0] {
    CRWL_M_IDLE   = 3'b000,
    CRWL_M_CHECK  = 3'b001,
    CRWL_M_UNLOCK = 3'b010,
    CRWL_M_PAD    = 3'b011,
    CRWL_M_RELOCK = 3'b100,
    CRWL_M_DONE   = 3'b101,
    CRWL_M_FAIL   = 3'b110
  } crwl_mstate_t;
endpackage : crwl_pkg

/* design/crwl_if.sv */
// control-space bus between the processor master and the lock guard
`timescale 1ns/1ns
`default_nettype none
interface crwl_if;
  import crwl_pkg::*;
  logic                   req;
  logic                   we;
  logic [CRWL_ADDR_W-1:0] addr;
  logic [CRWL_DATA_W-1:0] wdata;
  logic                   ack;
  logic                   err;
  logic [CRWL_DATA_W-1:0] rdata;
  modport dev (input req, we, addr, wdata, output ack, err, rdata);
  modport mst (output req, we, addr, wdata, input ack, err, rdata);
endinterface : crwl_if
`default_nettype wire

/* design/crwl_key_decode.sv */
// per-region key decoder for lock word writes
`timescale 1ns/1ns
`default_nettype none
module crwl_key_decode
  import crwl_pkg::*;
(
  input  wire logic [CRWL_REGION_W-1:0] idx,      // lock word index
  input  wire logic [CRWL_DATA_W-1:0]   wdata,    // written value
  output logic      [CRWL_DATA_W-1:0]   lock_key, // key read back when locked
  output logic                          is_lock,  // value is locking key
  output logic                          is_unlock // value is unlocking key
);
  logic [CRWL_DATA_W-1:0] unlock_key;

  always_comb begin
    case (idx)
      3'h0: begin
        lock_key   = CRWL_LOCK_KEY0;
        unlock_key = CRWL_UNLOCK_KEY0;
      end
      3'h1: begin
        lock_key   = CRWL_LOCK_KEY1;
        unlock_key = CRWL_UNLOCK_KEY1;
      end
      3'h2: begin
        lock_key   = CRWL_LOCK_KEY2;
        unlock_key = CRWL_UNLOCK_KEY2;
      end
      3'h3: begin
        lock_key   = CRWL_LOCK_KEY3;
        unlock_key = CRWL_UNLOCK_KEY3;
      end
      3'h4: begin
        lock_key   = CRWL_LOCK_KEY5;
        unlock_key = CRWL_UNLOCK_KEY5;
      end
      default: begin
        lock_key   = CRWL_ZERO32;
        unlock_key = CRWL_ZERO32;
      end
    endcase
  end

  assign is_lock   = (wdata == lock_key);
  assign is_unlock = (wdata == unlock_key);
endmodule : crwl_key_decode
`default_nettype wire

/* design/crwl_guard.sv */
// device end: control space with five lock words
// Notes on behaviour
// - five lock words, one per region
// - writes into locked region are dropped, lock words excepted
// - lock key locks, unlock key unlocks
// - fifth keys fixed; reads back lock key
// - locked fifth-region write blocks whole space
// - that write answers with bus error
// - blockage lasts until reset
// - master checks fifth word, unlocks first
// - master writes pads, then relocks
// - master never writes locked pad region
`timescale 1ns/1ns
`default_nettype none
module crwl_guard
  import crwl_pkg::*;
#(
  parameter int WORDS = 512 // register words per region
) (
  input  wire logic ref_clk,    // clock
  input  wire logic rst,        // synchronous reset
  crwl_if.dev       bus,        // control-space bus
  output logic [4:0] locked,    // region lock states
  output logic       blocked    // control space dead
);
  localparam int IDX_W = $clog2(WORDS);
  logic [CRWL_DATA_W-1:0]   mem [CRWL_NUM_REGIONS][WORDS];
  logic [CRWL_DATA_W-1:0]   next_mem_word;
  logic [4:0]               next_locked;
  logic                     next_blocked;
  logic                     ack_q, err_q, next_ack, next_err;
  logic [CRWL_DATA_W-1:0]   next_rdata;
  logic [CRWL_REGION_W-1:0] region, lock_idx;
  logic [IDX_W-1:0]         word;
  logic                     is_lock_word, is_lock, is_unlock, do_store;
  logic [CRWL_DATA_W-1:0]   lock_key;

  assign region   = bus.addr[CRWL_ADDR_W-1:CRWL_REGION_LSB];
  assign word     = bus.addr[IDX_W+1:2];
  assign lock_idx = 3'((bus.addr - CRWL_LOCK_BASE) >> 2);
  assign is_lock_word = (bus.addr >= CRWL_LOCK_BASE) &&
    (bus.addr < CRWL_LOCK_BASE + 12'(CRWL_NUM_REGIONS) * CRWL_LOCK_STRIDE);

  crwl_key_decode u_key (
    .idx       (lock_idx),
    .wdata     (bus.wdata),
    .lock_key  (lock_key),
    .is_lock   (is_lock),
    .is_unlock (is_unlock)
  );

  function automatic logic in_map(input logic [CRWL_REGION_W-1:0] r);
    in_map = (r < 3'(CRWL_NUM_REGIONS));
  endfunction : in_map

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic [CRWL_DATA_W-1:0] rd_key;
    rd_key        = CRWL_ZERO32;
    next_locked   = locked;
    next_blocked  = blocked;
    next_ack      = 1'b0;
    next_err      = 1'b0;
    next_rdata    = bus.rdata;
    do_store      = 1'b0;
    next_mem_word = bus.wdata;
    if (bus.req && !ack_q && !err_q) begin
      if (blocked) begin
        next_err = 1'b1;
      end else if (!in_map(region)) begin
        next_err = 1'b1;
      end else if (bus.we) begin
        if (is_lock_word) begin
          if (is_lock) next_locked[lock_idx] = 1'b1;
          else if (is_unlock) next_locked[lock_idx] = 1'b0;
          next_ack = 1'b1;
        end else if (locked[region] && region == CRWL_FIFTH_IDX) begin
          next_err     = 1'b1;
          next_blocked = 1'b1;
        end else begin
          do_store = !locked[region];
          next_ack = 1'b1;
        end
      end else begin
        next_ack = 1'b1;
        if (is_lock_word) begin
          rd_key     = locked[lock_idx] ? lock_key : CRWL_UNLOCKED_RD;
          next_rdata = rd_key;
        end else begin
          next_rdata = mem[region][word];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      locked    <= CRWL_LOCK_RESET;
      blocked   <= 1'b0;
      ack_q     <= 1'b0;
      err_q     <= 1'b0;
      bus.rdata <= CRWL_ZERO32;
    end else begin
      locked    <= next_locked;
      blocked   <= next_blocked;
      ack_q     <= next_ack;
      err_q     <= next_err;
      bus.rdata <= next_rdata;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (do_store && !rst) begin
      mem[region][word] <= next_mem_word;
    end
  end

  assign bus.ack = ack_q;
  assign bus.err = err_q;
endmodule : crwl_guard
`default_nettype wire

/* design/crwl_master.sv */
// master end: safe pad-region update sequence
`timescale 1ns/1ns
`default_nettype none
module crwl_master
  import crwl_pkg::*;
(
  input  wire logic                   ref_clk,  // clock
  input  wire logic                   rst,      // synchronous reset
  crwl_if.mst                         bus,      // control-space bus
  input  wire logic                   start,    // begin one pad update pulse
  input  wire logic [CRWL_ADDR_W-1:0] pad_addr, // pad register address
  input  wire logic [CRWL_DATA_W-1:0] pad_data, // pad register value
  output logic                        busy,     // sequence running
  output logic                        done,     // finished pulse
  output logic                        fail      // error seen pulse
);
  localparam logic [11:0] LOCK5_ADDR =
    CRWL_LOCK_BASE + CRWL_LOCK_STRIDE * 12'(CRWL_FIFTH_IDX);
  crwl_mstate_t state, next_state;
  logic                   next_we;
  logic [CRWL_ADDR_W-1:0] next_addr, a_q;
  logic [CRWL_DATA_W-1:0] next_wdata, d_q;
  logic                   next_done, next_fail;

  always_comb begin
    next_state = state;
    next_we    = bus.we;
    next_addr  = bus.addr;
    next_wdata = bus.wdata;
    next_done  = 1'b0;
    next_fail  = 1'b0;
    case (state)
      CRWL_M_IDLE: begin
        if (start) begin
          next_state = CRWL_M_CHECK;
          next_we    = 1'b0;
          next_addr  = LOCK5_ADDR;
        end
      end
      CRWL_M_CHECK: begin
        if (bus.ack) begin
          next_we = 1'b1;
          if (bus.rdata == CRWL_LOCK_KEY5) begin
            next_state = CRWL_M_UNLOCK;
            next_addr  = LOCK5_ADDR;
            next_wdata = CRWL_UNLOCK_KEY5;
          end else begin
            next_state = CRWL_M_PAD;
            next_addr  = a_q;
            next_wdata = d_q;
          end
        end else if (bus.err) begin
          next_state = CRWL_M_FAIL;
        end
      end
      CRWL_M_UNLOCK: begin
        if (bus.ack) begin
          next_state = CRWL_M_PAD;
          next_addr  = a_q;
          next_wdata = d_q;
        end else if (bus.err) begin
          next_state = CRWL_M_FAIL;
        end
      end
      CRWL_M_PAD: begin
        if (bus.ack) begin
          next_state = CRWL_M_RELOCK;
          next_addr  = LOCK5_ADDR;
          next_wdata = CRWL_LOCK_KEY5;
        end else if (bus.err) begin
          next_state = CRWL_M_FAIL;
        end
      end
      CRWL_M_RELOCK: begin
        if (bus.ack) begin
          next_state = CRWL_M_DONE;
        end else if (bus.err) begin
          next_state = CRWL_M_FAIL;
        end
      end
      CRWL_M_DONE: begin
        next_done  = 1'b1;
        next_state = CRWL_M_IDLE;
      end
      CRWL_M_FAIL: begin
        next_fail  = 1'b1;
        next_state = CRWL_M_IDLE;
      end
      default: begin
        next_state = CRWL_M_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  logic req_q;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state     <= CRWL_M_IDLE;
      req_q     <= 1'b0;
      bus.we    <= 1'b0;
      bus.addr  <= 12'h000;
      bus.wdata <= CRWL_ZERO32;
      a_q       <= 12'h000;
      d_q       <= CRWL_ZERO32;
      done      <= 1'b0;
      fail      <= 1'b0;
    end else begin
      state     <= next_state;
      req_q     <= (next_state != state) &&
                   (next_state == CRWL_M_CHECK || next_state == CRWL_M_UNLOCK ||
                    next_state == CRWL_M_PAD || next_state == CRWL_M_RELOCK);
      bus.we    <= (next_state == CRWL_M_CHECK) ? 1'b0 : next_we;
      bus.addr  <= next_addr;
      bus.wdata <= next_wdata;
      if (state == CRWL_M_IDLE && start) begin
        a_q <= pad_addr;
        d_q <= pad_data;
      end
      done <= next_done;
      fail <= next_fail;
    end
  end

  assign bus.req = req_q;
  assign busy    = (state != CRWL_M_IDLE);
endmodule : crwl_master
`default_nettype wire

/* verification/crwl_assertions.sv */
// checker on the control-space bus between master and guard
`timescale 1ns/1ns
`default_nettype none
module crwl_assertions
  import crwl_pkg::*;
(
  input wire logic        ref_clk, // clock
  input wire logic        rst,     // sync reset
  input wire logic        req,     // request pulse
  input wire logic        we,      // write
  input wire logic [11:0] addr,    // byte address
  input wire logic [31:0] wdata,   // write data
  input wire logic        ack,     // ok answer
  input wire logic        err,     // error answer
  input wire logic [31:0] rdata    // read data
);
  localparam logic [11:0] LW5 =
    CRWL_LOCK_BASE + CRWL_LOCK_STRIDE * 12'(CRWL_FIFTH_IDX);
  logic lk5;
  logic next_lk5;
  logic wlk;
  logic pad;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  assign wlk = req && we && addr == LW5;
  assign pad = req && we && addr[11:9] == CRWL_FIFTH_IDX;
  // expected fifth lock state as seen from the wire
  always_comb begin
    next_lk5 = lk5;
    if (wlk && wdata == CRWL_LOCK_KEY5) next_lk5 = 1'b1;
    if (wlk && wdata == CRWL_UNLOCK_KEY5) next_lk5 = 1'b0;
  end
  always_ff @(posedge ref_clk) lk5 <= rst ? 1'b0 : next_lk5;
  property p_answer; req |=> (ack ^ err); endproperty
  property p_no_stray; (ack || err) |-> $past(req); endproperty
  property p_lock_read;
    (req && !we && addr == LW5) |=>
      rdata == ($past(lk5) ? CRWL_LOCK_KEY5 : CRWL_UNLOCKED_RD);
  endproperty
  property p_lock_write; wlk |=> ack && !err; endproperty
  property p_unlock_first;
    (ack && rdata == CRWL_LOCK_KEY5 && $past(req && !we && addr == LW5))
      |-> ##[0:8] (wlk && wdata == CRWL_UNLOCK_KEY5);
  endproperty
  property p_pad_unlocked; pad |-> !lk5; endproperty
  property p_pad_ok; pad |=> ack && !err; endproperty
  property p_relock;
    pad |-> ##[1:8] (wlk && wdata == CRWL_LOCK_KEY5);
  endproperty
  a_answer: assert property (p_answer)
    else $error("request not answered exactly once");
  a_no_stray: assert property (p_no_stray)
    else $error("answer without request");
  a_lock_read: assert property (p_lock_read)
    else $error("fifth lock word read back wrong");
  a_lock_write: assert property (p_lock_write)
    else $error("lock word write refused");
  a_unlock_first: assert property (p_unlock_first)
    else $error("locked fifth word not unlocked");
  a_pad_unlocked: assert property (p_pad_unlocked)
    else $error("pad write while fifth region locked");
  a_pad_ok: assert property (p_pad_ok)
    else $error("pad write refused");
  a_relock: assert property (p_relock)
    else $error("fifth region not relocked");
  c_unlock: cover property (wlk && wdata == CRWL_UNLOCK_KEY5);
  c_pad: cover property (pad);
  c_err: cover property (err);
endmodule : crwl_assertions
`default_nettype wire

/* verification/control_region_write_lock_tb.sv */
// testbench: master and guard pair, plus a guard driven directly
`timescale 1ns/1ns
`default_nettype none
module control_region_write_lock_tb;
  import crwl_pkg::*;
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic        start = 1'b0;
  logic [11:0] pad_addr = 12'h000;
  logic [31:0] pad_data = 32'h00000000;
  logic        busy, done, fail, blocked_a, blocked_b, s_ack, s_err;
  logic        s_done, s_fail;
  logic [4:0]  locked_a, locked_b;
  logic [31:0] pad_seen, s_rd;
  logic [31:0] lk [5];
  logic [31:0] uk [5];
  logic [11:0] ta, lw;
  int          err_total = 0, n_tests = 0, nreq = 0;
  crwl_if bus_a ();
  crwl_if bus_b ();
  crwl_guard u_crwl_guard (.ref_clk(ref_clk), .rst(rst), .bus(bus_a),
    .locked(locked_a), .blocked(blocked_a));
  crwl_guard u_crwl_guard_b (.ref_clk(ref_clk), .rst(rst), .bus(bus_b),
    .locked(locked_b), .blocked(blocked_b));
  crwl_master u_crwl_master (.ref_clk(ref_clk), .rst(rst), .bus(bus_a),
    .start(start), .pad_addr(pad_addr), .pad_data(pad_data), .busy(busy),
    .done(done), .fail(fail));
  crwl_assertions u_crwl_assertions (.ref_clk(ref_clk), .rst(rst),
    .req(bus_a.req), .we(bus_a.we), .addr(bus_a.addr), .wdata(bus_a.wdata),
    .ack(bus_a.ack), .err(bus_a.err), .rdata(bus_a.rdata));
  always #50 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    if (bus_a.req === 1'b1) nreq <= nreq + 1;
    if (bus_a.req && bus_a.we && bus_a.addr == pad_addr)
      pad_seen <= bus_a.wdata;
  end
  ////////////////////////////////////////////////////////////////////////////
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] ex);
    n_tests++;
    if (seen !== ex) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, ex, seen);
    end
  endtask : chk
  // one bus_b access; reads expecting no error compare against d
  task acc(input logic w, input logic [11:0] a, input logic [31:0] d,
           input logic e);
    @(posedge ref_clk);
    bus_b.req <= 1'b1;
    bus_b.we <= w;
    bus_b.addr <= a;
    bus_b.wdata <= d;
    @(posedge ref_clk);
    bus_b.req <= 1'b0;
    @(negedge ref_clk);
    chk("err", 32'(bus_b.err), 32'(e));
    chk("ack", 32'(bus_b.ack), 32'(!e));
    if (!w && !e) chk("rdata", bus_b.rdata, d);
  endtask : acc
  task run(input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    start <= 1'b1;
    pad_addr <= a;
    pad_data <= d;
    @(posedge ref_clk);
    start <= 1'b0;
    s_done = 1'b0;
    s_fail = 1'b0;
    @(negedge ref_clk);
    chk("busy", 32'(busy), 32'h1);
    for (int k = 0; k < 40 && !(s_done || s_fail); k++) begin
      @(negedge ref_clk);
      if (done === 1'b1) s_done = 1'b1;
      if (fail === 1'b1) s_fail = 1'b1;
    end
    chk("idle", 32'(busy), 32'h0);
  endtask : run
  task final_report;
    if (err_total == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : final_report
  ////////////////////////////////////////////////////////////////////////////
  task run_all;
    lk = '{CRWL_LOCK_KEY0, CRWL_LOCK_KEY1, CRWL_LOCK_KEY2, CRWL_LOCK_KEY3,
           CRWL_LOCK_KEY5};
    uk = '{CRWL_UNLOCK_KEY0, CRWL_UNLOCK_KEY1, CRWL_UNLOCK_KEY2,
           CRWL_UNLOCK_KEY3, CRWL_UNLOCK_KEY5};
    bus_b.req = 1'b0;
    bus_b.we = 1'b0;
    bus_b.addr = 12'h000;
    bus_b.wdata = 32'h00000000;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    @(negedge ref_clk);
    chk("reset_a", 32'({locked_a, blocked_a}), 32'h0);
    chk("reset_b", 32'({locked_b, blocked_b}), 32'h0);
    run(12'h820, 32'hA5A50001);
    chk("nreq1", 32'(nreq), 32'h3);
    chk("done1", 32'(s_done), 32'h1);
    chk("pad1", pad_seen, 32'hA5A50001);
    chk("relock1", 32'(locked_a), 32'h10);
    run(12'h824, 32'h5A5A0002);
    chk("nreq2", 32'(nreq), 32'h7);
    chk("done2", 32'(s_done), 32'h1);
    chk("pad2", pad_seen, 32'h5A5A0002);
    chk("relock2", 32'(locked_a), 32'h10);
    run(12'hA00, 32'h00000001);
    chk("fail", 32'(s_fail), 32'h1);
    for (int i = 0; i < 5; i++) begin
      ta = 12'(i * 512 + 16);
      lw = CRWL_LOCK_BASE + 12'(4 * i);
      acc(1'b1, ta, 32'hC0DE0000 + i, 1'b0);
      acc(1'b1, lw, lk[i], 1'b0);
      chk("lock", 32'(locked_b), 32'(1 << i));
      acc(1'b0, lw, lk[i], 1'b0);
      acc(1'b1, lw, 32'h0BAD0BAD, 1'b0);
      chk("other", 32'(locked_b), 32'(1 << i));
      if (i < 4) begin
        acc(1'b1, ta, 32'hFFFFFFFF, 1'b0);
        acc(1'b0, ta, 32'hC0DE0000 + i, 1'b0);
      end
      acc(1'b1, lw, uk[i], 1'b0);
      chk("unlock", 32'(locked_b), 32'h0);
      acc(1'b0, lw, CRWL_UNLOCKED_RD, 1'b0);
      acc(1'b1, ta, 32'h12340000 + i, 1'b0);
      acc(1'b0, ta, 32'h12340000 + i, 1'b0);
    end
    acc(1'b1, 12'h1F0, CRWL_LOCK_KEY5, 1'b0);
    acc(1'b1, 12'h810, 32'h00000001, 1'b1);
    chk("blocked", 32'(blocked_b), 32'h1);
    acc(1'b0, 12'h010, 32'h0, 1'b1);
    acc(1'b1, 12'h1F0, CRWL_UNLOCK_KEY5, 1'b1);
    acc(1'b0, 12'h810, 32'h0, 1'b1);
    chk("stuck", 32'(blocked_b), 32'h1);
  endtask : run_all
  ////////////////////////////////////////////////////////////////////////////
  // the tests race a cycle ceiling; running out counts as a mismatch
  initial begin
    fork
      run_all();
      begin
        repeat (3000) @(posedge ref_clk);
        chk("timeout", 32'h1, 32'h0);
      end
    join_any
    final_report();
  end
endmodule : control_region_write_lock_tb
`default_nettype wire
